// >>> hw/qdw_pkg.sv
// Constants and types shared by the quad DAC two-wire command port.
// Assumes a 16-bit command word and four channels A to D.
package qdw_pkg;

    // Fixed upper part of the 7-bit slave address
    localparam logic [4:0] ADDR_FIXED = 5'h03;

    // Command word layout
    localparam int WORD_W = 16;
    localparam int GAIN_POS = 15;
    localparam int BUF_POS = 14;
    localparam int CLEAR_POS = 13;
    localparam int POWER_DOWN_POS = 12;
    localparam int CODE_MSB = 11;
    localparam int CODE_W_DEF = 12;

    // Channel pointer layout
    localparam int NUM_CH = 4;
    localparam int SEL_LSB = 0;

    // Reset values
    localparam logic [3:0] PTR_RST = 4'h0;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic GAIN_RST = 1'b0;
    localparam logic BUF_RST = 1'b0;
    localparam logic CLEAR_N_RST = 1'b1;
    localparam logic POWER_DOWN_N_RST = 1'b1;

    // Bit counter value of the eighth data bit
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [3:0] {
        QDW_IDLE = 4'h0,
        QDW_ADDR = 4'h1,
        QDW_AACK = 4'h3,
        QDW_PTR = 4'h2,
        QDW_PACK = 4'h6,
        QDW_WDAT = 4'h7,
        QDW_WACK = 4'h5,
        QDW_RDAT = 4'hb,
        QDW_RACK = 4'ha
    } qdw_state_t;

endpackage

// >>> hw/qdw_evt_if.sv
// Event carrier from the bus clock side to the system clock side.
// Assumes the source toggles tgl once per event and holds it otherwise.
`timescale 1ns/1ps
interface qdw_evt_if;
    logic tgl;
    logic pulse;
    modport src (output tgl, input pulse);
    modport dst (input tgl, output pulse);
endinterface

// >>> hw/qdw_evt_sync.sv
// Toggle synchroniser: turns a foreign-domain toggle into a one-cycle
// pulse on sys_clk. Assumes toggles are spaced by several sys_clk cycles.
`timescale 1ns/1ps
module qdw_evt_sync
    import qdw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    qdw_evt_if.dst evt
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } qdw_sync_t;

    qdw_sync_t s_reg;
    qdw_sync_t s_next;

    ////////////////////////////////////////////////////////////////////
    // The first stage feeds only the second one
    always_comb begin
        s_next = s_reg;
        s_next.meta = evt.tgl;
        s_next.sync = s_reg.meta;
        s_next.last = s_reg.sync;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign evt.pulse = s_reg.sync ^ s_reg.last;

endmodule

// >>> hw/qdw_cmd_port.sv
// Two-wire slave port and command logic of a quad voltage DAC.
// Assumes scl_in is the bus clock driven by the master, sda is an
// open-drain line resolved outside, and the straps are static.
//
// Operation
// - Answer address 00011 followed by the two strap pin levels.
// - Slave only; never drive the clock line.
// - Detect start as data falling while clock is high.
// - On address match, hold data low during the ninth clock.
// - On mismatch stay idle and silent until the next start.
// - Bytes are eight bits MSB first plus one acknowledge bit.
// - Change data only while clock low; stable while clock high.
// - Write is address, pointer byte, then data bytes.
// - Full read writes pointer, then resends address for reading.
// - Read without pointer uses the last written pointer.
// - Pointer top two bits ignored, next two zero, low four select.
// - Data goes to every channel whose select bit is one.
// - Two data bytes assemble into the 16-bit input word.
// - Word holds gain, buffer, clear, power-down, then code.
// - Gain zero gives one times reference, one gives twice.
// - Buffer bit applies to selected channels; one means buffered.
// - Clear bit zero zeroes all channel and input registers.
// - Power-down bit zero powers down all four channels.
// - Power-on: normal mode, unbuffered, single range, zero output.
// - Pointer powers up zero; readback then shows clear, power-down.
// - Several selected channels get the same bits at once.
// - Multi-channel readback returns zeros plus clear and power-down.
`timescale 1ns/1ps
module qdw_cmd_port
    import qdw_pkg::*;
#(
    parameter int CODE_W = CODE_W_DEF
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_strap_low,
    input wire logic address_strap_high,
    output logic [NUM_CH-1:0][CODE_W-1:0] dac_code,
    output logic [NUM_CH-1:0] dac_gain,
    output logic [NUM_CH-1:0] dac_buf,
    output logic dac_power_down,
    output logic dac_update
);

    ////////////////////////////////////////////////////////////////////
    // Bus clock side state

    typedef struct packed {
        qdw_state_t st;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic wr_lo;
        logic rd_lo;
        logic [1:0] strap_m;
        logic [1:0] strap_s;
        logic start_seen;
        logic commit_tgl;
        logic [3:0] channel_pointer;
        logic [WORD_W-1:0] input_shift_word;
        logic [WORD_W-1:0] tx;
        logic [NUM_CH-1:0] gain;
        logic [NUM_CH-1:0] bufr;
        logic [NUM_CH-1:0][CODE_W-1:0] code;
        logic clear_all_active_low;
        logic power_down_active_low;
    } qdw_link_t;

    typedef struct packed {
        logic [NUM_CH-1:0][CODE_W-1:0] code;
        logic [NUM_CH-1:0] gain;
        logic [NUM_CH-1:0] bufr;
        logic pwr_dn;
        logic upd;
    } qdw_sys_t;

    qdw_link_t l_reg;
    qdw_link_t l_next;
    qdw_sys_t s_reg;
    qdw_sys_t s_next;
    logic oe_reg;
    logic oe_next;
    logic start_tgl_reg;
    logic [7:0] byte_in;
    logic [7:0] tx_byte;
    logic start_hit;
    logic addr_hit;

    qdw_evt_if commit_evt ();

    ////////////////////////////////////////////////////////////////////
    // Readback word for the current pointer

    function automatic logic [WORD_W-1:0] readback(qdw_link_t s);
        logic [WORD_W-1:0] w;
        // A pointer that is not one-hot reads back only clear and power-down
        w = WORD_RST;
        w[CLEAR_POS] = s.clear_all_active_low;
        w[POWER_DOWN_POS] = s.power_down_active_low;
        for (int i = 0; i < NUM_CH; i++) begin
            if (s.channel_pointer == 4'(1 << i)) begin
                w[GAIN_POS] = s.gain[i];
                w[BUF_POS] = s.bufr[i];
                w[CODE_MSB -: CODE_W] = s.code[i];
            end
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Start detector, clocked by the data line itself.
    // The toggle settles while the clock is high, a half period before
    // the next rising clock edge reads it.
    // A stop is not decoded: the port simply waits for the next start.

    always_ff @(negedge sda_in or negedge rst_b) begin
        if (!rst_b) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bit engine on the rising bus clock edge

    assign start_hit = start_tgl_reg != l_reg.start_seen;
    assign byte_in = {l_reg.sh[6:0], sda_in};
    assign addr_hit = byte_in[7:1] == {ADDR_FIXED, l_reg.strap_s};

    always_comb begin
        l_next = l_reg;
        l_next.strap_m = {address_strap_high, address_strap_low};
        l_next.strap_s = l_reg.strap_m;
        l_next.sh = byte_in;
        l_next.cnt = 3'(l_reg.cnt + 3'h1);
        if (start_hit) begin
            // First address bit arrives on the edge after the start
            l_next.start_seen = start_tgl_reg;
            l_next.st = QDW_ADDR;
            l_next.cnt = 3'h1;
        end else begin
            unique case (l_reg.st)
                QDW_IDLE: begin
                    l_next.cnt = l_reg.cnt;
                end
                QDW_ADDR: begin
                    if (l_reg.cnt == LAST_BIT) begin
                        if (addr_hit) begin
                            l_next.st = QDW_AACK;
                            l_next.rw = byte_in[0];
                        end else begin
                            l_next.st = QDW_IDLE;
                        end
                    end
                end
                QDW_AACK: begin
                    l_next.cnt = 3'h0;
                    if (l_reg.rw) begin
                        // Direct read keeps the stored pointer
                        l_next.st = QDW_RDAT;
                        l_next.rd_lo = 1'b0;
                        l_next.tx = readback(l_reg);
                    end else begin
                        l_next.st = QDW_PTR;
                    end
                end
                QDW_PTR: begin
                    if (l_reg.cnt == LAST_BIT) begin
                        l_next.st = QDW_PACK;
                        // Top four bits carry nothing the port uses
                        l_next.channel_pointer =
                            byte_in[SEL_LSB +: NUM_CH];
                    end
                end
                QDW_PACK: begin
                    l_next.st = QDW_WDAT;
                    l_next.cnt = 3'h0;
                    l_next.wr_lo = 1'b0;
                end
                QDW_WDAT: begin
                    if (l_reg.cnt == LAST_BIT) begin
                        l_next.st = QDW_WACK;
                        if (l_reg.wr_lo) begin
                            l_next.input_shift_word[7:0] = byte_in;
                        end else begin
                            l_next.input_shift_word[15:8] =
                                byte_in;
                        end
                    end
                end
                QDW_WACK: begin
                    l_next.st = QDW_WDAT;
                    l_next.cnt = 3'h0;
                    l_next.wr_lo = ~l_reg.wr_lo;
                    if (l_reg.wr_lo) begin
                        // Second byte acknowledged: apply the word
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (l_reg.channel_pointer[i]) begin
                                l_next.gain[i] =
                                    l_reg.input_shift_word[GAIN_POS];
                                l_next.bufr[i] =
                                    l_reg.input_shift_word[BUF_POS];
                                l_next.code[i] = l_reg.input_shift_word
                                    [CODE_MSB -: CODE_W];
                            end
                        end
                        l_next.clear_all_active_low =
                            l_reg.input_shift_word[CLEAR_POS];
                        l_next.power_down_active_low =
                            l_reg.input_shift_word[POWER_DOWN_POS];
                        if (!l_reg.input_shift_word[CLEAR_POS]) begin
                            l_next.code = '0;
                            l_next.input_shift_word = WORD_RST;
                        end
                        l_next.commit_tgl = ~l_reg.commit_tgl;
                    end
                end
                QDW_RDAT: begin
                    if (l_reg.cnt == LAST_BIT) begin
                        l_next.st = QDW_RACK;
                    end
                end
                QDW_RACK: begin
                    l_next.cnt = 3'h0;
                    if (!sda_in) begin
                        l_next.st = QDW_RDAT;
                        l_next.rd_lo = ~l_reg.rd_lo;
                    end else begin
                        // Not-acknowledge ends the read
                        l_next.st = QDW_IDLE;
                    end
                end
                default: begin
                    l_next.st = QDW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_in or negedge rst_b) begin
        if (!rst_b) begin
            l_reg <= '0;
            l_reg.st <= QDW_IDLE;
            l_reg.channel_pointer <= PTR_RST;
            l_reg.input_shift_word <= WORD_RST;
            l_reg.gain <= {NUM_CH{GAIN_RST}};
            l_reg.bufr <= {NUM_CH{BUF_RST}};
            l_reg.clear_all_active_low <= CLEAR_N_RST;
            l_reg.power_down_active_low <= POWER_DOWN_N_RST;
        end else begin
            l_reg <= l_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data line driver on the falling bus clock edge, so the line only
    // moves while the clock is low

    assign tx_byte = l_reg.rd_lo ? l_reg.tx[7:0] : l_reg.tx[15:8];

    always_comb begin
        oe_next = 1'b0;
        unique case (l_reg.st)
            QDW_AACK, QDW_PACK, QDW_WACK: begin
                oe_next = 1'b1;
            end
            QDW_RDAT: begin
                oe_next = ~tx_byte[3'(LAST_BIT - l_reg.cnt)];
            end
            default: begin
                oe_next = 1'b0;
            end
        endcase
        // A start pending means the master owns the line
        if (start_hit) begin
            oe_next = 1'b0;
        end
    end

    always_ff @(negedge scl_in or negedge rst_b) begin
        if (!rst_b) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= oe_next;
        end
    end

    // Open drain: only ever pulls low, and the clock is never driven
    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;

    ////////////////////////////////////////////////////////////////////
    // Hand-over of applied words to the system clock side

    assign commit_evt.tgl = l_reg.commit_tgl;

    qdw_evt_sync u_commit_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .evt(commit_evt)
    );

    // Channel state is still for many bus clocks after a toggle, so it
    // is safe to sample once the synchronised pulse arrives
    always_comb begin
        s_next = s_reg;
        s_next.upd = commit_evt.pulse;
        if (commit_evt.pulse) begin
            s_next.code = l_reg.code;
            s_next.gain = l_reg.gain;
            s_next.bufr = l_reg.bufr;
            s_next.pwr_dn = ~l_reg.power_down_active_low;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.gain <= {NUM_CH{GAIN_RST}};
            s_reg.bufr <= {NUM_CH{BUF_RST}};
            s_reg.pwr_dn <= ~POWER_DOWN_N_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dac_code = s_reg.code;
    assign dac_gain = s_reg.gain;
    assign dac_buf = s_reg.bufr;
    assign dac_power_down = s_reg.pwr_dn;
    assign dac_update = s_reg.upd;

endmodule

// >>> dv/qdw_cmd_port_props.sv
// Bus and output checks for the two-wire command port.
// Assumes straps stay static while a frame is on the bus.
`timescale 1ns/1ps
module qdw_cmd_port_props
    import qdw_pkg::*;
#(
    parameter int CODE_W = CODE_W_DEF
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic address_strap_low,
    input wire logic address_strap_high,
    input wire logic [NUM_CH-1:0][CODE_W-1:0] dac_code,
    input wire logic [NUM_CH-1:0] dac_gain,
    input wire logic [NUM_CH-1:0] dac_buf,
    input wire logic dac_power_down,
    input wire logic dac_update
);
    // Rise counter; a start restarts it so each byte lands at fixed counts
    logic st_tgl;
    logic st_seen;
    logic addr_ok;
    logic addr_rd;
    logic oe_rise;
    logic [4:0] cnt;
    logic [7:0] sh;
    logic [6:0] own;
    assign own = {ADDR_FIXED, address_strap_high, address_strap_low};
    always_ff @(negedge sda_in or negedge rst_b) begin
        if (!rst_b) st_tgl <= 1'b0;
        else if (scl_in) st_tgl <= ~st_tgl;
    end
    always_ff @(posedge scl_in or negedge rst_b) begin
        if (!rst_b) begin
            st_seen <= 1'b0;
            cnt <= 5'h1f;
            sh <= 8'h00;
            addr_ok <= 1'b0;
            addr_rd <= 1'b0;
            oe_rise <= 1'b0;
        end else begin
            oe_rise <= sda_oe;
            sh <= {sh[6:0], sda_in};
            st_seen <= st_tgl;
            if (st_tgl != st_seen) cnt <= 5'h01;
            else if (cnt != 5'h1f) cnt <= cnt + 5'h01;
            if (cnt == 5'h08) begin
                addr_ok <= (sh[7:1] == own);
                addr_rd <= sh[0];
            end
        end
    end
    ////////////////////////////////////////
    a_addr_ack: assert property (
        @(posedge scl_in) disable iff (!rst_b)
        cnt == 5'h08 |-> sda_oe == (sh[7:1] == own))
        else $error("address ack wrong");
    a_addr_quiet: assert property (
        @(posedge scl_in) disable iff (!rst_b)
        (st_tgl != st_seen || cnt < 5'h08) |-> !sda_oe)
        else $error("driven in address bits");
    a_mismatch_silent: assert property (
        @(posedge scl_in) disable iff (!rst_b)
        (cnt > 5'h08 && !addr_ok && st_tgl == st_seen) |-> !sda_oe)
        else $error("driven after mismatch");
    a_ptr_ack: assert property (
        @(posedge scl_in) disable iff (!rst_b)
        (cnt == 5'h11 && addr_ok && !addr_rd) |-> sda_oe)
        else $error("pointer not acked");
    a_oe_stable_high: assert property (
        @(negedge scl_in) disable iff (!rst_b) sda_oe == oe_rise)
        else $error("data moved with clock high");
    a_update_pulse: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        dac_update |=> !dac_update)
        else $error("update longer than one cycle");
    a_outputs_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !dac_update |-> $stable(dac_code) && $stable(dac_gain)
            && $stable(dac_buf) && $stable(dac_power_down))
        else $error("outputs moved without update");
    a_reset_state: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(rst_b) |-> dac_code == '0 && dac_gain == 4'h0
            && dac_buf == 4'h0 && !dac_power_down && !sda_oe)
        else $error("reset state wrong");
endmodule
bind qdw_cmd_port qdw_cmd_port_props #(.CODE_W(CODE_W)) u_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap_low(address_strap_low),
    .address_strap_high(address_strap_high),
    .dac_code(dac_code), .dac_gain(dac_gain), .dac_buf(dac_buf),
    .dac_power_down(dac_power_down), .dac_update(dac_update));

// >>> dv/qdw_master_model.sv
// Two-wire bus master model; it alone makes the bus clock.
// Assumes a pull-up outside; sda_drv high means released.
`timescale 1ns/1ps
module qdw_master_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda_in
);
    // Quarter of the 64 ns bus clock period
    localparam int Q = 16;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    ////////////////////////////////////////
    task automatic start();
        sda_drv = 1'b1;
        #Q scl = 1'b1;
        #Q sda_drv = 1'b0;
        #Q scl = 1'b0;
    endtask
    task automatic bit_io(input logic b, output logic s);
        #Q sda_drv = b;
        #Q scl = 1'b1;
        #Q s = sda_in;
        #Q scl = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
    // Clock is left high afterwards: it stands still between frames
    task automatic stop();
        #Q sda_drv = 1'b0;
        #Q scl = 1'b1;
        #Q sda_drv = 1'b1;
        #Q;
    endtask
endmodule

// >>> dv/test_qdw_cmd_port.sv
// Self-checking bench for the two-wire command port.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
module test_qdw_cmd_port
    import qdw_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap_lo = 1'b0;
    logic strap_hi = 1'b0;
    logic scl;
    logic sda_drv;
    logic sda_w;
    logic sda_out;
    logic sda_oe;
    logic [NUM_CH-1:0][CODE_W_DEF-1:0] dac_code;
    logic [3:0] dac_gain;
    logic [3:0] dac_buf;
    logic dac_power_down;
    logic dac_update;
    logic [NUM_CH-1:0][CODE_W_DEF-1:0] exp_code = '0;
    logic [3:0] exp_gain = 4'h0;
    logic [3:0] exp_buf = 4'h0;
    logic exp_pwr_dn = 1'b0;
    logic clear_n = CLEAR_N_RST;
    logic pwr_dn_n = POWER_DOWN_N_RST;
    logic [7:0] cur_ptr = 8'h00;
    logic [6:0] dev_addr = {ADDR_FIXED, 2'h3};
    int failures = 0;
    int check_count = 0;
    int exp_upd = 0;
    int upd_cnt = 0;
    always #25 sys_clk = ~sys_clk;
    // Open drain with pull-up: any low wins
    assign sda_w = sda_drv & ~(sda_oe & ~sda_out);
    // Counted mid-cycle, where the one-cycle pulse has settled
    always @(negedge sys_clk) if (dac_update === 1'b1) upd_cnt++;
    qdw_cmd_port uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .address_strap_low(strap_lo), .address_strap_high(strap_hi),
        .dac_code(dac_code), .dac_gain(dac_gain), .dac_buf(dac_buf),
        .dac_power_down(dac_power_down), .dac_update(dac_update));
    qdw_master_model mst (.scl(scl), .sda_drv(sda_drv), .sda_in(sda_w));
    ////////////////////////////////////////
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check_outs();
        chk(48'(dac_code), 48'(exp_code));
        chk(48'(dac_gain), 48'(exp_gain));
        chk(48'(dac_buf), 48'(exp_buf));
        chk(48'(dac_power_down), 48'(exp_pwr_dn));
        chk(48'(upd_cnt), 48'(exp_upd));
    endtask
    task automatic apply(input logic [7:0] p, input logic [15:0] w);
        for (int c = 0; c < NUM_CH; c++) begin
            if (p[SEL_LSB + c]) begin
                exp_gain[c] = w[GAIN_POS];
                exp_buf[c] = w[BUF_POS];
                exp_code[c] = w[CODE_MSB -: CODE_W_DEF];
            end
        end
        // A cleared write zeroes every channel, selected or not
        if (!w[CLEAR_POS]) exp_code = '0;
        clear_n = w[CLEAR_POS];
        pwr_dn_n = w[POWER_DOWN_POS];
        exp_pwr_dn = !w[POWER_DOWN_POS];
        exp_upd++;
    endtask
    function automatic logic [15:0] rb_word(input logic [3:0] p);
        logic [15:0] w;
        w = {2'h0, clear_n, pwr_dn_n, 12'h000};
        for (int c = 0; c < NUM_CH; c++) begin
            if (p == 4'(1 << c))
                w = {exp_gain[c], exp_buf[c], clear_n, pwr_dn_n, exp_code[c]};
        end
        return w;
    endfunction
    task automatic probe(input logic [6:0] a, input logic nack);
        logic ack;
        mst.start();
        mst.wr_byte({a, 1'b0}, ack);
        mst.stop();
        chk(48'(ack), 48'(nack));
    endtask
    task automatic dev_write(input logic [7:0] p, input logic [15:0] w,
                             input logic full);
        logic [3:0] ack;
        ack = 4'h0;
        mst.start();
        mst.wr_byte({dev_addr, 1'b0}, ack[3]);
        mst.wr_byte(p, ack[2]);
        mst.wr_byte(w[15:8], ack[1]);
        if (full) mst.wr_byte(w[7:0], ack[0]);
        mst.stop();
        cur_ptr = p;
        if (full) apply(p, w);
        repeat (8) @(posedge sys_clk);
        #2 chk(48'(ack), 48'h0);
        check_outs();
    endtask
    task automatic dev_read(input logic use_ptr, input logic [7:0] p);
        logic [2:0] ack;
        logic [15:0] d;
        ack = 3'h0;
        mst.start();
        if (use_ptr) begin
            mst.wr_byte({dev_addr, 1'b0}, ack[2]);
            mst.wr_byte(p, ack[1]);
            mst.start();
            cur_ptr = p;
        end
        mst.wr_byte({dev_addr, 1'b1}, ack[0]);
        mst.rd_byte(1'b0, d[15:8]);
        mst.rd_byte(1'b1, d[7:0]);
        mst.stop();
        chk(48'(ack), 48'h0);
        chk(48'(d), 48'(rb_word(cur_ptr[3:0])));
    endtask
    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        #2 rst_b = 1'b1;
        check_outs();
        // First probe per strap value also lets the strap sync settle
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk);
            #2 {strap_hi, strap_lo} = 2'(s);
            probe({5'h02, 2'(s)}, 1'b1);
            probe({ADDR_FIXED, 2'(s ^ 3)}, 1'b1);
            probe({ADDR_FIXED, 2'(s)}, 1'b0);
        end
        dev_read(1'b0, 8'h00);
        dev_write(8'h01, 16'hbabc, 1'b1);
        dev_write(8'hc6, 16'h7123, 1'b1);
        dev_read(1'b1, 8'h04);
        dev_read(1'b0, 8'h00);
        dev_read(1'b1, 8'h03);
        dev_write(8'h08, 16'hafff, 1'b1);
        dev_write(8'h02, 16'h5555, 1'b1);
        dev_read(1'b1, 8'h02);
        dev_write(8'h01, 16'hff00, 1'b0);
        dev_write(8'h0f, 16'hf321, 1'b1);
        tally_and_finish();
    end
endmodule
